// ---- rtl/bil_core.sv ----
// Branch, index, compare, transfer and jump subset of an 8-bit processor
// Notes on behaviour
// - Immediate accumulator load sets zero flag on zero, clears it otherwise.
// - Branch-if-zero is taken when zero flag set, else falls through.
// - Branches decide from current status register flags only.
// - Branch-if-not-zero is taken when zero flag clear.
// - Increment X adds one, wrapping FF to 00.
// - Decrement X subtracts one, wrapping 00 to FF.
// - Y increment and decrement behave like X, with wrap.
// - Compare X/Y against immediate or memory updates flags; equal sets zero.
// - Branch operand is one signed byte, range -128 to +127.
// - Subroutine call takes an absolute address and jumps there.
// - Absolute jump loads the program counter with its operand.
// - Copy X to accumulator leaves X unchanged.
`timescale 1ns/1ns
`include "bil_consts.svh"
module bil_core (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [7:0] mem_rdata_i,
  output bil_pkg::bil_bus_req_s bus_o,
  output bil_pkg::bil_regs_s regs_o,
  output logic [15:0] pc_o,
  output logic bad_op_o
);
  import bil_pkg::*;

  bil_state_s st_ff;
  bil_state_s nxt_st;
  logic [7:0] rd_q1_ff;
  logic [7:0] rd_ff;

  // Read data arrives from outside; two stages before any decode looks at it
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      rd_q1_ff <= `BIL_ZERO_BYTE;
      rd_ff <= `BIL_ZERO_BYTE;
    end else begin
      rd_q1_ff <= mem_rdata_i;
      rd_ff <= rd_q1_ff;
    end
  end

  // Helpers for operand width
  function automatic logic [1:0] oper_bytes(input logic [7:0] op);
    case (op)
      `BIL_OP_LDA_IMM, `BIL_OP_BEQ, `BIL_OP_BNE,
      `BIL_OP_CPX_IMM, `BIL_OP_CPY_IMM: oper_bytes = 2'd1;
      `BIL_OP_CPX_ABS, `BIL_OP_CPY_ABS, `BIL_OP_JSR, `BIL_OP_JMP: oper_bytes = 2'd2;
      default: oper_bytes = 2'd0;
    endcase
  endfunction

  // Compare sets carry on no-borrow and zero on equality
  function automatic logic [7:0] cmp_flags(input logic [7:0] p, input logic [7:0] r,
                                           input logic [7:0] m);
    logic [7:0] f;
    f = p;
    f[`BIL_FLAG_Z] = (r == m);
    f[`BIL_FLAG_C] = (r >= m);
    f[7] = logic'((r - m) >> 7);
    cmp_flags = f;
  endfunction

  // Sequencer: a read takes four cycles because of the input synchroniser,
  // so the bus address is held and the state waits on a small count
  logic [1:0] wait_ff;
  logic [1:0] nxt_wait;
  logic data_ok;
  assign data_ok = (wait_ff == 2'd3);

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      wait_ff <= 2'd0;
    end else begin
      wait_ff <= nxt_wait;
    end
  end

  always_comb begin
    logic [7:0] opnd;
    logic [15:0] nxt_pc_seq;
    logic take;
    opnd = rd_ff;
    nxt_pc_seq = st_ff.pc;
    take = 1'b0;
    nxt_st = st_ff;
    nxt_wait = (st_ff.bus.rd && !data_ok) ? wait_ff + 2'd1 : 2'd0;
    case (st_ff.state)
      BIL_FETCH: begin
        nxt_st.bus.addr = st_ff.pc;
        nxt_st.bus.rd = 1'b1;
        nxt_st.state = BIL_DECODE;
      end
      BIL_DECODE: begin
        if (data_ok) begin
          nxt_st.op = opnd;
          nxt_st.pc = st_ff.pc + 16'd1;
          if (oper_bytes(opnd) != 2'd0) begin
            nxt_st.bus.addr = st_ff.pc + 16'd1;
            nxt_st.state = BIL_OPER1;
          end else begin
            nxt_st.bus.rd = 1'b0;
            nxt_st.state = BIL_EXEC;
          end
        end
      end
      BIL_OPER1: begin
        if (data_ok) begin
          nxt_st.lo = opnd;
          nxt_st.pc = st_ff.pc + 16'd1;
          if (oper_bytes(st_ff.op) == 2'd2) begin
            nxt_st.bus.addr = st_ff.pc + 16'd1;
            nxt_st.state = BIL_OPER2;
          end else begin
            nxt_st.bus.rd = 1'b0;
            nxt_st.state = BIL_EXEC;
          end
        end
      end
      BIL_OPER2: begin
        if (data_ok) begin
          nxt_st.hi = opnd;
          nxt_st.pc = st_ff.pc + 16'd1;
          if (st_ff.op == `BIL_OP_CPX_ABS || st_ff.op == `BIL_OP_CPY_ABS) begin
            nxt_st.bus.addr = {opnd, st_ff.lo}; // Memory operand of compare
            nxt_st.state = BIL_MEMRD;
          end else begin
            nxt_st.bus.rd = 1'b0;
            nxt_st.state = BIL_EXEC;
          end
        end
      end
      BIL_MEMRD: begin
        if (data_ok) begin
          nxt_st.lo = opnd;
          nxt_st.bus.rd = 1'b0;
          nxt_st.state = BIL_EXEC;
        end
      end
      BIL_EXEC: begin
        nxt_st.state = BIL_FETCH;
        nxt_pc_seq = st_ff.pc; // Already points past the instruction
        case (st_ff.op)
          `BIL_OP_LDA_IMM: begin
            nxt_st.regs.a = st_ff.lo;
            nxt_st.regs.p[`BIL_FLAG_Z] = (st_ff.lo == `BIL_ZERO_BYTE);
            nxt_st.regs.p[7] = st_ff.lo[7];
          end
          `BIL_OP_BEQ, `BIL_OP_BNE: begin
            // Flag read straight from status register, never a shadow copy
            take = (st_ff.op == `BIL_OP_BEQ) ? st_ff.regs.p[`BIL_FLAG_Z]
                                            : !st_ff.regs.p[`BIL_FLAG_Z];
            if (take) begin
              nxt_st.pc = nxt_pc_seq + {{8{st_ff.lo[7]}}, st_ff.lo};
            end
          end
          `BIL_OP_INX, `BIL_OP_DEX: begin
            nxt_st.regs.x = (st_ff.op == `BIL_OP_INX) ? st_ff.regs.x + 8'd1
                                                     : st_ff.regs.x - 8'd1;
            nxt_st.regs.p[`BIL_FLAG_Z] = (nxt_st.regs.x == `BIL_ZERO_BYTE);
            nxt_st.regs.p[7] = nxt_st.regs.x[7];
          end
          `BIL_OP_INY, `BIL_OP_DEY: begin
            nxt_st.regs.y = (st_ff.op == `BIL_OP_INY) ? st_ff.regs.y + 8'd1
                                                     : st_ff.regs.y - 8'd1;
            nxt_st.regs.p[`BIL_FLAG_Z] = (nxt_st.regs.y == `BIL_ZERO_BYTE);
            nxt_st.regs.p[7] = nxt_st.regs.y[7];
          end
          `BIL_OP_CPX_IMM, `BIL_OP_CPX_ABS:
            nxt_st.regs.p = cmp_flags(st_ff.regs.p, st_ff.regs.x, st_ff.lo);
          `BIL_OP_CPY_IMM, `BIL_OP_CPY_ABS:
            nxt_st.regs.p = cmp_flags(st_ff.regs.p, st_ff.regs.y, st_ff.lo);
          // Return address stacking is outside this block; only the transfer is done
          `BIL_OP_JSR: nxt_st.pc = {st_ff.hi, st_ff.lo};
          `BIL_OP_JMP: nxt_st.pc = {st_ff.hi, st_ff.lo};
          `BIL_OP_TXA: begin
            nxt_st.regs.a = st_ff.regs.x;
            nxt_st.regs.p[`BIL_FLAG_Z] = (st_ff.regs.x == `BIL_ZERO_BYTE);
            nxt_st.regs.p[7] = st_ff.regs.x[7];
          end
          default: begin
            // Unknown opcodes stop the core rather than run wild
            nxt_st.bad_op = 1'b1;
            nxt_st.state = BIL_HALT;
          end
        endcase
      end
      BIL_HALT: nxt_st.bus.rd = 1'b0;
      default: nxt_st.state = BIL_FETCH;
    endcase
  end

  // Single state register
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      st_ff <= '{state: BIL_FETCH, pc: `BIL_RESET_PC, op: 8'h_0000, lo: 8'h_0000,
                 hi: 8'h_0000, regs: '0, bus: '0, bad_op: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state flops
  assign bus_o = st_ff.bus;
  assign regs_o = st_ff.regs;
  assign pc_o = st_ff.pc;
  assign bad_op_o = st_ff.bad_op;
endmodule

// ---- rtl/bil_consts.svh ----
// Constants for the branch and index logic: opcodes, reset vector, zero byte, flag bits
`ifndef BIL_CONSTS_SVH
`define BIL_CONSTS_SVH
`define BIL_OP_LDA_IMM 8'h_00A9
`define BIL_OP_BEQ 8'h_00F0
`define BIL_OP_BNE 8'h_00D0
`define BIL_OP_INX 8'h_00E8
`define BIL_OP_DEX 8'h_00CA
`define BIL_OP_INY 8'h_00C8
`define BIL_OP_DEY 8'h_0088
`define BIL_OP_CPX_IMM 8'h_00E0
`define BIL_OP_CPX_ABS 8'h_00EC
`define BIL_OP_CPY_IMM 8'h_00C0
`define BIL_OP_CPY_ABS 8'h_00CC
`define BIL_OP_JSR 8'h_0020
`define BIL_OP_JMP 8'h_004C
`define BIL_OP_TXA 8'h_008A
`define BIL_RESET_PC 16'h_0000
`define BIL_ZERO_BYTE 8'h_0000
`define BIL_FLAG_Z 1
`define BIL_FLAG_C 0
`endif

// ---- rtl/bil_pkg.sv ----
// Types shared by the branch and index logic
package bil_pkg;
  typedef enum logic [6:0] {
    BIL_FETCH = 7'b0000001,
    BIL_DECODE = 7'b0000010,
    BIL_OPER1 = 7'b0000100,
    BIL_OPER2 = 7'b0001000,
    BIL_MEMRD = 7'b0010000,
    BIL_EXEC = 7'b0100000,
    BIL_HALT = 7'b1000000
  } bil_state_e;

  typedef struct packed {
    logic [15:0] addr;
    logic rd;
  } bil_bus_req_s;

  typedef struct packed {
    logic [7:0] a;
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] p;
  } bil_regs_s;

  typedef struct packed {
    bil_state_e state;
    logic [15:0] pc;
    logic [7:0] op;
    logic [7:0] lo;
    logic [7:0] hi;
    bil_regs_s regs;
    bil_bus_req_s bus;
    logic bad_op;
  } bil_state_s;
endpackage

// ---- dv/bil_mem_model.sv ----
// Byte memory standing on the core's read bus
`timescale 1ns/1ns
module bil_mem_model (
  input wire logic clock_i,
  input bil_pkg::bil_bus_req_s bus_i,
  output logic [7:0] rdata_o
);
  import bil_pkg::*;
  logic [7:0] mem [256];
  logic [7:0] last_ff = 8'h_00;
  // Only 256 bytes: the high address byte is ignored, so programs alias
  // An idle bus shows the inverted last byte so stale data never looks valid
  assign rdata_o = bus_i.rd ? mem[bus_i.addr[7:0]] : ~last_ff;
  // Remember the byte last presented
  always_ff @(posedge clock_i) begin
    if (bus_i.rd) last_ff <= mem[bus_i.addr[7:0]];
  end
endmodule

// ---- dv/bil_core_checker.sv ----
// Port-level checker for the branch and index core
`timescale 1ns/1ns
module bil_core_checker (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [7:0] mem_rdata_i,
  input bil_pkg::bil_bus_req_s bus_o,
  input bil_pkg::bil_regs_s regs_o,
  input wire logic [15:0] pc_o,
  input wire logic bad_op_o
);
  import bil_pkg::*;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // A byte read keeps its address through the synchroniser delay
  sequence s_hold;
    (bus_o.rd && $stable(bus_o.addr)) [*3];
  endsequence
  // Guards on past reset keep stale pre-reset values out of the checks
  a_reset_values: assert property ($rose(nrst_i) |-> pc_o == 16'h_0000 && regs_o == '0)
    else $error("state not cleared by reset");
  a_first_fetch: assert property ($rose(nrst_i) |-> ##[1:3] bus_o.rd && bus_o.addr == 16'h_0000)
    else $error("no fetch from address zero after reset");
  a_x_steps: assert property ($past(nrst_i) && $changed(regs_o.x) |->
    regs_o.x - $past(regs_o.x) inside {8'h_01, 8'h_FF}) else $error("x moved by other than one");
  a_y_steps: assert property ($past(nrst_i) && $changed(regs_o.y) |->
    regs_o.y - $past(regs_o.y) inside {8'h_01, 8'h_FF}) else $error("y moved by other than one");
  a_copy_keeps_x: assert property ($past(nrst_i) && $changed(regs_o.a) |-> $stable(regs_o.x))
    else $error("x disturbed when a changed");
  a_zero_on_a: assert property ($past(nrst_i) && $changed(regs_o.a) |->
    regs_o.p[1] == (regs_o.a == 8'h_00)) else $error("zero flag wrong after load");
  a_zero_on_x: assert property ($past(nrst_i) && $changed(regs_o.x) |->
    regs_o.p[1] == (regs_o.x == 8'h_00) && regs_o.p[7] == regs_o.x[7]) else $error("x flags wrong");
  a_read_holds: assert property ($rose(bus_o.rd) |=> s_hold)
    else $error("read address moved too early");
  a_halt_quiet: assert property (bad_op_o |=> bad_op_o && !bus_o.rd && $stable(pc_o))
    else $error("core ran on after bad opcode");
endmodule
bind bil_core bil_core_checker u_chk (.clock_i, .nrst_i, .mem_rdata_i, .bus_o, .regs_o, .pc_o,
  .bad_op_o);

// ---- dv/tb_bil_core.sv ----
// Self-checking bench running a short program through the core
`timescale 1ns/1ns
`include "bil_consts.svh"
`define TB_CMP(g, e, m) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value at %0t: %s", $time, m); end end
module tb_bil_core;
  import bil_pkg::*;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] rdata;
  bil_bus_req_s bus;
  bil_regs_s regs;
  logic [15:0] pc;
  logic bad_op;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  bil_core u_dut (.clock_i, .nrst_i, .mem_rdata_i(rdata), .bus_o(bus), .regs_o(regs),
    .pc_o(pc), .bad_op_o(bad_op));
  bil_mem_model u_mem (.clock_i, .bus_i(bus), .rdata_o(rdata));
  // Clock with a 50 ns period
  initial forever #25 clock_i = ~clock_i;
  // Hang guard: the program needs well under a thousand cycles
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic ld(input logic [7:0] ad, input logic [7:0] q [$]);
    foreach (q[i]) u_mem.mem[ad + 8'(i)] = q[i];
  endtask
  // Wait for the opcode fetch at ad, then check what the prior instruction left
  task automatic at(input logic [15:0] ad, input logic [7:0] a, input logic [7:0] x,
    input logic [7:0] y, input logic z);
    for (int n = 0; n < 300 && !(bus.rd === 1'b1 && bus.addr === ad); n++) @(negedge clock_i);
    `TB_CMP({pc, regs.a, regs.x, regs.y, regs.p[1]}, {ad, a, x, y, z}, "state at fetch")
  endtask
  task automatic t_load_branch();
    at(16'h_0002, 8'h_00, 8'h_00, 8'h_00, 1'b1);
    at(16'h_0083, 8'h_00, 8'h_00, 8'h_00, 1'b1);
  endtask
  task automatic t_index_wrap();
    at(16'h_0084, 8'h_00, 8'h_FF, 8'h_00, 1'b0);
    at(16'h_0085, 8'h_00, 8'h_00, 8'h_00, 1'b1);
    at(16'h_0086, 8'h_00, 8'h_00, 8'h_FF, 1'b0);
    at(16'h_0087, 8'h_00, 8'h_00, 8'h_00, 1'b1);
    at(16'h_0088, 8'h_00, 8'h_01, 8'h_00, 1'b0);
  endtask
  task automatic t_compare_branch();
    at(16'h_008A, 8'h_00, 8'h_01, 8'h_00, 1'b0);
    at(16'h_008C, 8'h_00, 8'h_01, 8'h_00, 1'b1);
    at(16'h_008E, 8'h_00, 8'h_01, 8'h_00, 1'b1);
    at(16'h_0091, 8'h_00, 8'h_01, 8'h_00, 1'b1);
    at(16'h_0092, 8'h_01, 8'h_01, 8'h_00, 1'b0);
    at(16'h_0014, 8'h_01, 8'h_01, 8'h_00, 1'b0);
    at(16'h_0017, 8'h_01, 8'h_01, 8'h_00, 1'b1);
    at(16'h_0019, 8'h_01, 8'h_01, 8'h_00, 1'b0);
  endtask
  task automatic t_jumps();
    at(16'h_0040, 8'h_01, 8'h_01, 8'h_00, 1'b0);
    at(16'h_0050, 8'h_01, 8'h_01, 8'h_00, 1'b0);
    at(16'h_0052, 8'h_80, 8'h_01, 8'h_00, 1'b0);
    for (int n = 0; n < 50 && bad_op !== 1'b1; n++) @(negedge clock_i);
    `TB_CMP({bad_op, bus.rd}, 2'b10, "no halt on bad opcode")
  endtask
  // A second reset after the bad-opcode halt must restart from address zero
  task automatic t_reset();
    @(posedge clock_i) nrst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    @(negedge clock_i);
    `TB_CMP({pc, regs, bad_op}, 49'h_0000_0000_0000_0, "reset state")
    @(posedge clock_i) nrst_i <= 1'b1;
    at(16'h_0002, 8'h_00, 8'h_00, 8'h_00, 1'b1);
  endtask
  // Unwritten bytes hold an unsupported opcode, so a wrong path halts
  initial begin
    foreach (u_mem.mem[i]) u_mem.mem[i] = 8'h_00;
    ld(8'h_00, '{`BIL_OP_LDA_IMM, 8'h_00, `BIL_OP_BEQ, 8'h_7F});
    ld(8'h_83, '{`BIL_OP_DEX, `BIL_OP_INX, `BIL_OP_DEY, `BIL_OP_INY, `BIL_OP_INX, `BIL_OP_BEQ,
      8'h_00, `BIL_OP_CPX_IMM, 8'h_01, `BIL_OP_BNE, 8'h_00, `BIL_OP_CPX_ABS, 8'h_F0, 8'h_00,
      `BIL_OP_TXA, `BIL_OP_BNE, 8'h_80});
    ld(8'h_14, '{`BIL_OP_CPY_ABS, 8'h_F1, 8'h_00, `BIL_OP_CPY_IMM, 8'h_05, `BIL_OP_JSR, 8'h_40,
      8'h_00});
    ld(8'h_40, '{`BIL_OP_JMP, 8'h_50, 8'h_00});
    // A non-zero load must keep the zero flag clear, as the last compare left it
    ld(8'h_50, '{`BIL_OP_LDA_IMM, 8'h_80});
    ld(8'h_F0, '{8'h_01, 8'h_00});
    repeat (16) @(posedge clock_i);
    nrst_i <= 1'b1;
    t_load_branch();
    t_index_wrap();
    t_compare_branch();
    t_jumps();
    t_reset();
    wrap_up();
  end
endmodule
